// file: logic/ident_chain.sv
// Peripheral-side identification and base address decode on a daisy chain
// Behaviour
// - Power-up, manual or commanded reset returns module to unenumerated state.
// - After reset only a module whose left neighbour enables it responds.
// - Enabled unenumerated module answers identification port reads with type/state word.
// - Port zero write stores base address and raises chain enable output on the same clock edge.
// - After enumeration, identification port reads and writes are ignored until reset or until chain enable input drops.
// - Base address may be reprogrammed at any time after enumeration.
// - On power-up the chain enable output flip-flop is cleared low.
// - While chain enable input is low, stored base address is held cleared.
// - Enabled but not yet passing on, the module answers at address zero.
// - Stored base selects upper address byte, programmable 01h to FFh.
`timescale 1ns/1ps
`default_nettype none
module ident_chain
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Commanded reset from host
  input wire logic soft_reset,
  // Chain
  input wire logic chain_enable_in,
  output logic chain_enable_out,
  // Host I/O cycle
  input wire ident_chain_pkg::io_req_s io_req,
  output logic [ident_chain_pkg::DATA_W-1:0] rdata,
  output logic rdata_valid,
  // Own register space select
  output logic own_sel,
  output logic [7:0] own_offset,
  output logic [7:0] base_addr
);
  import ident_chain_pkg::*;

  chain_state_e state, next_state;
  logic next_chain_enable_out;
  logic [7:0] next_base_addr;
  logic [DATA_W-1:0] next_rdata;
  logic next_rdata_valid;
  logic next_own_sel;
  logic [7:0] next_own_offset;
  logic id_hit;

  function automatic logic is_id_port(input logic [ADDR_W-1:0] a);
    return a == {ID_PORT_HI, ID_PORT_LO};
  endfunction

  // Upper byte picks the module, low byte the register inside it
  function automatic logic [7:0] upper_byte(input logic [ADDR_W-1:0] v);
    return v[BASE_MSB:BASE_LSB];
  endfunction

  function automatic logic [7:0] lower_byte(input logic [ADDR_W-1:0] v);
    return v[OFFS_MSB:OFFS_LSB];
  endfunction

  // Responds at port zero only while enabled and not yet passing on
  assign id_hit = chain_enable_in && !chain_enable_out && is_id_port(io_req.addr);

  always_comb begin
    next_state = state;
    next_chain_enable_out = chain_enable_out;
    next_base_addr = base_addr;
    next_rdata = rdata;
    next_rdata_valid = 1'b0;
    next_own_sel = 1'b0;
    next_own_offset = own_offset;
    if (soft_reset) begin
      next_state = ST_IDLE;
      next_chain_enable_out = 1'b0;
      next_base_addr = BASE_RESET;
    end else if (!chain_enable_in) begin
      // Upstream lost its enable, so this module drops back too
      next_state = ST_IDLE;
      next_chain_enable_out = 1'b0;
      next_base_addr = BASE_RESET;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_ENABLED;
        end
        ST_ENABLED: begin
          if (id_hit && io_req.rd) begin
            next_rdata = TYPE_STATE_WORD;
            next_rdata_valid = 1'b1;
          end else if (id_hit && io_req.wr && upper_byte(io_req.wdata) != BASE_RESET) begin
            // Zero is refused: it would alias the identification port
            next_base_addr = upper_byte(io_req.wdata);
            next_chain_enable_out = 1'b1;
            next_state = ST_ENUMERATED;
          end
        end
        ST_ENUMERATED: begin
          // Port zero no longer decoded here
          if (upper_byte(io_req.addr) == base_addr && (io_req.rd || io_req.wr)) begin
            next_own_sel = 1'b1;
            next_own_offset = lower_byte(io_req.addr);
            if (io_req.wr && lower_byte(io_req.addr) == ID_PORT_LO
                && upper_byte(io_req.wdata) != BASE_RESET) begin
              next_base_addr = upper_byte(io_req.wdata);
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      chain_enable_out <= 1'b0;
      base_addr <= BASE_RESET;
      rdata <= '0;
      rdata_valid <= 1'b0;
      own_sel <= 1'b0;
      own_offset <= '0;
    end else begin
      state <= next_state;
      chain_enable_out <= next_chain_enable_out;
      base_addr <= next_base_addr;
      rdata <= next_rdata;
      rdata_valid <= next_rdata_valid;
      own_sel <= next_own_sel;
      own_offset <= next_own_offset;
    end
  end

  property p_out_low_when_in_low;
    @(posedge sys_clk) disable iff (!nrst)
    !chain_enable_in |=> !chain_enable_out;
  endproperty
  a_out_low_when_in_low: assert property (p_out_low_when_in_low)
    else $error("chain enable out high while input low");

  property p_soft_reset;
    @(posedge sys_clk) disable iff (!nrst)
    soft_reset |=> !chain_enable_out && base_addr == BASE_RESET;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("commanded reset did not clear module");

  property p_id_read;
    @(posedge sys_clk) disable iff (!nrst)
    !soft_reset && chain_enable_in && state == ST_ENABLED && io_req.rd && is_id_port(io_req.addr)
      |=> rdata_valid && rdata == TYPE_STATE_WORD;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identification read not answered");

  property p_id_write;
    @(posedge sys_clk) disable iff (!nrst)
    !soft_reset && chain_enable_in && state == ST_ENABLED && io_req.wr && !io_req.rd
      && is_id_port(io_req.addr) && upper_byte(io_req.wdata) != BASE_RESET
      |=> chain_enable_out && base_addr == $past(io_req.wdata[BASE_MSB:BASE_LSB]);
  endproperty
  a_id_write: assert property (p_id_write)
    else $error("base write did not store and pass enable");

  property p_ignore_after;
    @(posedge sys_clk) disable iff (!nrst)
    chain_enable_out && io_req.rd && is_id_port(io_req.addr) |=> !rdata_valid;
  endproperty
  a_ignore_after: assert property (p_ignore_after)
    else $error("port zero answered after enumeration");

  property p_clear_base;
    @(posedge sys_clk) disable iff (!nrst)
    !chain_enable_in |=> base_addr == BASE_RESET;
  endproperty
  a_clear_base: assert property (p_clear_base)
    else $error("base not cleared while input low");

  property p_own_sel;
    @(posedge sys_clk) disable iff (!nrst)
    own_sel |-> $past(chain_enable_out) && $past(io_req.addr[15:8]) == $past(base_addr);
  endproperty
  a_own_sel: assert property (p_own_sel)
    else $error("own select without matching upper byte");

  property p_base_nonzero;
    @(posedge sys_clk) disable iff (!nrst)
    chain_enable_out |-> base_addr != BASE_RESET;
  endproperty
  a_base_nonzero: assert property (p_base_nonzero)
    else $error("enumerated with base zero");

  property p_reprogram;
    @(posedge sys_clk) disable iff (!nrst)
    !soft_reset && chain_enable_in && state == ST_ENUMERATED && io_req.wr
      && io_req.addr == {base_addr, ID_PORT_LO} && upper_byte(io_req.wdata) != BASE_RESET
      |=> base_addr == $past(io_req.wdata[BASE_MSB:BASE_LSB]);
  endproperty
  a_reprogram: assert property (p_reprogram)
    else $error("base reprogram not taken");

  property p_silent_unenabled;
    @(posedge sys_clk) disable iff (!nrst)
    !chain_enable_in |=> !rdata_valid && !own_sel;
  endproperty
  a_silent_unenabled: assert property (p_silent_unenabled)
    else $error("module answered while not enabled");

  // Any write outside the own range must leave the base alone
  property p_base_held;
    @(posedge sys_clk) disable iff (!nrst)
    chain_enable_out && chain_enable_in && !soft_reset
      && !(io_req.wr && upper_byte(io_req.addr) == base_addr)
      |=> base_addr == $past(base_addr);
  endproperty
  a_base_held: assert property (p_base_held)
    else $error("base changed without a write to own range");

  property p_no_own_before_enum;
    @(posedge sys_clk) disable iff (!nrst)
    !chain_enable_out |=> !own_sel;
  endproperty
  a_no_own_before_enum: assert property (p_no_own_before_enum)
    else $error("own select before enumeration");

  c_id_read: cover property (@(posedge sys_clk) disable iff (!nrst) rdata_valid);
  c_enum: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(chain_enable_out));
  c_own: cover property (@(posedge sys_clk) disable iff (!nrst) own_sel);
  c_reprog: cover property (@(posedge sys_clk) disable iff (!nrst)
    chain_enable_out && $changed(base_addr));
endmodule
`default_nettype wire

// file: logic/ident_chain_pkg.sv
// Package for the module identification chain
package ident_chain_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [7:0] ID_PORT_HI = 8'h00;
  localparam logic [7:0] ID_PORT_LO = 8'h00;
  localparam logic [7:0] BASE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] TYPE_STATE_WORD = 16'h5a01;
  // Field positions of the base byte and the register offset
  localparam int BASE_MSB = 15;
  localparam int BASE_LSB = 8;
  localparam int OFFS_MSB = 7;
  localparam int OFFS_LSB = 0;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } io_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ENABLED = 3'b010,
    ST_ENUMERATED = 3'b100
  } chain_state_e;
endpackage

// file: test/host_model.sv
// Host-side model: bootstrap I/O cycles and the left chain enable
`timescale 1ns/1ps
`default_nettype none
module host_model
  import ident_chain_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Toward the block
  output var ident_chain_pkg::io_req_s io_req,
  output var logic chain_enable_in,
  // From the block
  input wire logic rdata_valid
);
  initial begin
    io_req = '0;
    chain_enable_in = 1'b0;
  end
  // One cycle per access; released lines show the inverse, never a stale value
  task automatic acc(input logic rd, input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    io_req <= '{rd: rd, wr: wr, addr: a, wdata: d};
    @(negedge sys_clk);
    io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // No answer a cycle after a port zero read means the end of the chain
  task automatic probe(output logic present);
    acc(1'b1, 1'b0, 16'h0000, 16'h0000);
    present = rdata_valid;
  endtask
  // Left enable, driven as soon as the task is called; the bench calls it on the falling edge
  task automatic set_enable(input logic en);
    chain_enable_in <= en;
  endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the identification chain block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ident_chain_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic soft_reset = 1'b0;
  logic chain_enable_in, chain_enable_out, rdata_valid, own_sel;
  io_req_s io_req;
  logic [DATA_W-1:0] rdata, a;
  logic [7:0] own_offset, base_addr, b, nb;
  logic present;
  int seed = 79861;
  int err_count = 0;
  int compares = 0;
  always #20 sys_clk = ~sys_clk;
  host_model host_u (.sys_clk(sys_clk), .io_req(io_req), .chain_enable_in(chain_enable_in),
    .rdata_valid(rdata_valid));
  ident_chain dut_u (.sys_clk(sys_clk), .nrst(nrst), .soft_reset(soft_reset),
    .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out), .io_req(io_req),
    .rdata(rdata), .rdata_valid(rdata_valid), .own_sel(own_sel), .own_offset(own_offset),
    .base_addr(base_addr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic hit(input logic [15:0] ad, input logic [7:0] bs);
    return ad[15:8] == bs;
  endfunction
  task automatic results;
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    results;
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    chk(chain_enable_out, 0);
    chk(base_addr, 0);
    host_u.probe(present);
    chk(rdata_valid, 0);
    chk(present, 0);
    for (int i = 0; i < 20; i++) begin
      b = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : 8'($random(seed));
      if (b == 8'h00) b = 8'h42;
      host_u.set_enable(1'b1);
      @(negedge sys_clk);
      host_u.acc(1, 0, 16'h0000, 16'($random(seed)));
      chk(rdata_valid, 1);
      chk(rdata, TYPE_STATE_WORD);
      // Base zero is not a legal assignment, module must stay unenumerated
      if (i == 2) host_u.acc(0, 1, 16'h0000, 16'h0003);
      chk(chain_enable_out, 0);
      // Read and write together: the read wins, no enumeration yet
      if (i == 3) begin
        host_u.acc(1, 1, 16'h0000, {b, 8'h00});
        chk(rdata_valid, 1);
        chk(chain_enable_out, 0);
      end
      host_u.acc(0, 1, 16'h0000, {b, 8'(i + 1)});
      chk(chain_enable_out, 1);
      chk(base_addr, b);
      host_u.acc(1, 1, 16'h0000, 16'h0000);
      chk(rdata_valid, 0);
      chk(base_addr, b);
      a = i[0] ? {b, 8'($random(seed))} : 16'($random(seed));
      host_u.acc(1, 0, a, 16'h0000);
      chk(own_sel, hit(a, b));
      if (hit(a, b)) chk(own_offset, a[7:0]);
      nb = (b == 8'hff) ? 8'h01 : b + 8'h01;
      host_u.acc(0, 1, {b, 8'h00}, {nb, 8'h00});
      chk(base_addr, nb);
      // Odd passes drop the left enable, pass ten pulls the system reset
      if (i[0]) host_u.set_enable(1'b0);
      else if (i == 10) nrst <= 1'b0;
      else soft_reset <= 1'b1;
      @(negedge sys_clk);
      soft_reset <= 1'b0;
      nrst <= 1'b1;
      chk(chain_enable_out, 0);
      chk(base_addr, 0);
    end
    results;
  end
endmodule
`default_nettype wire
